// >>> rtl/lvd_ctrl_pkg.sv
/*
  Shared constants for the supply voltage detector control block: register
  offsets, field positions, reset values and trip-level codes.
  Assumes an 8-bit register port with a 4-bit word address.
*/
package lvd_ctrl_pkg;

  // Register port geometry.
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // Register offsets on the plain register port.
  localparam logic [3:0] OFS_INTERRUPT_GLOBAL_CONTROL = 4'h0;
  localparam logic [3:0] OFS_PERIPHERAL_INTERRUPT_ENABLE_ONE = 4'h1;
  localparam logic [3:0] OFS_PERIPHERAL_INTERRUPT_FLAGS_ONE = 4'h2;
  localparam logic [3:0] OFS_VOLTAGE_DETECT_CONTROL = 4'h3;

  // Field positions in interrupt_global_control.
  localparam int unsigned BIT_GLOBAL_IRQ_ENABLE = 7;
  localparam int unsigned BIT_PERIPHERAL_IRQ_ENABLE = 6;

  // Field positions in the peripheral enable and flag registers.
  localparam int unsigned BIT_LOW_VOLTAGE_IRQ_ENABLE = 6;
  localparam int unsigned BIT_LOW_VOLTAGE_EVENT_FLAG = 6;

  // Field positions in voltage_detect_control.
  localparam int unsigned BIT_REFERENCE_STABLE_STATUS = 5;
  localparam int unsigned BIT_DETECTOR_ENABLE = 4;
  localparam int unsigned TRIP_LEVEL_LSB = 0;
  localparam int unsigned TRIP_LEVEL_W = 3;

  // Values after reset.
  localparam logic [7:0] RST_INTERRUPT_GLOBAL_CONTROL = 8'h00;
  localparam logic [7:0] RST_PERIPHERAL_INTERRUPT_ENABLE_ONE = 8'h00;
  localparam logic [7:0] RST_PERIPHERAL_INTERRUPT_FLAGS_ONE = 8'h00;
  localparam logic [7:0] RST_VOLTAGE_DETECT_CONTROL = 8'h04;

  // Trip-level codes, nominal supply levels in the names.
  localparam logic [2:0] TRIP_4V5 = 3'h7;
  localparam logic [2:0] TRIP_4V2 = 3'h6;
  localparam logic [2:0] TRIP_4V0 = 3'h5;
  localparam logic [2:0] TRIP_2V3 = 3'h4;
  localparam logic [2:0] TRIP_2V2 = 3'h3;
  localparam logic [2:0] TRIP_2V1 = 3'h2;
  localparam logic [2:0] TRIP_2V0 = 3'h1;
  localparam logic [2:0] TRIP_RESERVED = 3'h0;
  localparam logic [2:0] TRIP_RESET = TRIP_2V3;

  // Depth of the input synchronisers.
  localparam int unsigned SYNC_STAGES = 2;

  // Enabled cycles before the edge detector arms: the synchroniser depth plus
  // the cycle in which the comparator itself is still powering up.
  localparam logic [1:0] ARM_CYCLES = 2'h3;

endpackage

// >>> rtl/lvd_sync.sv
/*
  Two-flop synchroniser bank, one chain per bit.
  Assumes the inputs may change at any time relative to core_clk.
*/
`timescale 1ns/1ns
`default_nettype none

module lvd_sync #(
  parameter int unsigned WIDTH = 2
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] hold_ff;

  // The first stage feeds only the second stage.
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge core_clk) begin
        if (srst) begin
          meta_ff[i] <= 1'b0;
          hold_ff[i] <= 1'b0;
        end else begin
          meta_ff[i] <= async_in[i];
          hold_ff[i] <= meta_ff[i];
        end
      end
    end
  endgenerate

  assign sync_out = hold_ff;

endmodule // lvd_sync

`default_nettype wire

// >>> rtl/lvd_ctrl.sv
/*
  Control and event logic of the supply voltage detector: register port,
  enable and trip-level outputs to the analog detector, falling-edge event
  capture, interrupt request and wake-up from sleep.
  Assumes the analog comparator and reference drive plain levels that may
  be asynchronous, and a register master that follows the one-cycle strobe
  protocol with read data expected in the following cycle only.
*/
// The placing of the registers and the plain strobed port were decided locally.
// Contract
// - A falling supply crossing the trip level sets the event flag on its edge.
// - The event flag stays set until software writes it clear.
// - Control bits 2 to 0 choose one of seven trip levels or the reserved code.
// - Codes 7..1 select 4.5V down to 2.0V; 4 (2.3V) after reset; 0 reserved.
// - Interrupt only when flag, global, peripheral and low-voltage interrupt enables all set.
// - Software may write the flag to one, giving the same interrupt.
// - Control bit 5 reads the reference stable status, read only.
// - Control bit 4 powers the detector and its reference up or down.
// - Events wake the core in sleep; global enable also selects vectoring.
// - Control bits 7, 6 and 3 read zero and ignore writes.
`timescale 1ns/1ns
`default_nettype none

module lvd_ctrl (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic supply_above_trip,
  input wire logic reference_stable_raw,
  output logic detector_enable,
  output logic [2:0] trip_level_select,
  output logic irq_req,
  output logic wake_req,
  output logic vector_after_wake
);

  // Stored register state.
  logic global_irq_enable_ff;
  logic peripheral_irq_enable_ff;
  logic low_voltage_irq_enable_ff;
  logic low_voltage_event_flag_ff;
  logic detector_enable_ff;
  logic [2:0] trip_level_select_ff;
  logic supply_prev_ff;
  logic [1:0] arm_cnt_ff;
  logic [7:0] rdata_ff;

  // Next values.
  logic nxt_global_irq_enable;
  logic nxt_peripheral_irq_enable;
  logic nxt_low_voltage_irq_enable;
  logic nxt_low_voltage_event_flag;
  logic nxt_detector_enable;
  logic [2:0] nxt_trip_level_select;
  logic nxt_supply_prev;
  logic [1:0] nxt_arm_cnt;
  logic [7:0] nxt_rdata;

  // Synchronised analog levels.
  logic [1:0] sync_levels;
  wire supply_above_sync;
  wire reference_stable_status;

  // The comparator output and the reference flag are both free-running analog
  // levels; they are only ever looked at after the two-flop chain.
  lvd_sync #(
    .WIDTH(2)
  ) u_sync (
    .core_clk(core_clk),
    .srst(srst),
    .async_in({reference_stable_raw, supply_above_trip}),
    .sync_out(sync_levels)
  );

  assign supply_above_sync = sync_levels[0];
  assign reference_stable_status = sync_levels[1];

  // Address decode.
  wire sel_global = (reg_addr == lvd_ctrl_pkg::OFS_INTERRUPT_GLOBAL_CONTROL);
  wire sel_pie = (reg_addr == lvd_ctrl_pkg::OFS_PERIPHERAL_INTERRUPT_ENABLE_ONE);
  wire sel_pir = (reg_addr == lvd_ctrl_pkg::OFS_PERIPHERAL_INTERRUPT_FLAGS_ONE);
  wire sel_ctrl = (reg_addr == lvd_ctrl_pkg::OFS_VOLTAGE_DETECT_CONTROL);
  wire wr_global = reg_wr && sel_global;
  wire wr_pie = reg_wr && sel_pie;
  wire wr_pir = reg_wr && sel_pir;
  wire wr_ctrl = reg_wr && sel_ctrl;

  // Falling edge of the supply relative to the trip level. The previous
  // sample is forced low while disabled, so enabling with the supply already
  // above or below the level never looks like an edge, and powering down
  // cannot produce one either.
  // The synchroniser still carries samples taken while the comparator was
  // off, so the previous sample stays low until those have been flushed.
  wire armed = (arm_cnt_ff == lvd_ctrl_pkg::ARM_CYCLES);
  assign nxt_arm_cnt = !detector_enable_ff ? 2'h0
    : armed ? arm_cnt_ff
    : arm_cnt_ff + 2'h1;
  wire supply_fall = detector_enable_ff && supply_prev_ff && !supply_above_sync;
  assign nxt_supply_prev = detector_enable_ff && armed && supply_above_sync;

  // Flag: a hardware edge wins over a software clear in the same cycle, and
  // software may also write a one to fake an event.
  assign nxt_low_voltage_event_flag = supply_fall
    || (wr_pir ? reg_wdata[lvd_ctrl_pkg::BIT_LOW_VOLTAGE_EVENT_FLAG]
               : low_voltage_event_flag_ff);

  // Enables: plain stores. Nothing here checks the stable status before the
  // interrupt enable is taken; that order is left to software.
  assign nxt_global_irq_enable = wr_global
    ? reg_wdata[lvd_ctrl_pkg::BIT_GLOBAL_IRQ_ENABLE] : global_irq_enable_ff;
  assign nxt_peripheral_irq_enable = wr_global
    ? reg_wdata[lvd_ctrl_pkg::BIT_PERIPHERAL_IRQ_ENABLE] : peripheral_irq_enable_ff;
  assign nxt_low_voltage_irq_enable = wr_pie
    ? reg_wdata[lvd_ctrl_pkg::BIT_LOW_VOLTAGE_IRQ_ENABLE] : low_voltage_irq_enable_ff;

  // Control register: only bit 4 and bits 2..0 take writes.
  assign nxt_detector_enable = wr_ctrl
    ? reg_wdata[lvd_ctrl_pkg::BIT_DETECTOR_ENABLE] : detector_enable_ff;
  assign nxt_trip_level_select = wr_ctrl
    ? reg_wdata[lvd_ctrl_pkg::TRIP_LEVEL_LSB +: lvd_ctrl_pkg::TRIP_LEVEL_W]
    : trip_level_select_ff;

  // Read images; every unimplemented position reads zero.
  logic [7:0] img_global;
  logic [7:0] img_pie;
  logic [7:0] img_pir;
  logic [7:0] img_ctrl;

  always_comb begin
    img_global = 8'h00;
    img_global[lvd_ctrl_pkg::BIT_GLOBAL_IRQ_ENABLE] = global_irq_enable_ff;
    img_global[lvd_ctrl_pkg::BIT_PERIPHERAL_IRQ_ENABLE] = peripheral_irq_enable_ff;
    img_pie = 8'h00;
    img_pie[lvd_ctrl_pkg::BIT_LOW_VOLTAGE_IRQ_ENABLE] = low_voltage_irq_enable_ff;
    img_pir = 8'h00;
    img_pir[lvd_ctrl_pkg::BIT_LOW_VOLTAGE_EVENT_FLAG] = low_voltage_event_flag_ff;
    img_ctrl = 8'h00;
    img_ctrl[lvd_ctrl_pkg::BIT_REFERENCE_STABLE_STATUS] = reference_stable_status;
    img_ctrl[lvd_ctrl_pkg::BIT_DETECTOR_ENABLE] = detector_enable_ff;
    img_ctrl[lvd_ctrl_pkg::TRIP_LEVEL_LSB +: lvd_ctrl_pkg::TRIP_LEVEL_W] =
      trip_level_select_ff;
  end

  // Read data stand only in the cycle after the strobe; unmapped reads zero.
  assign nxt_rdata = !reg_rd ? 8'h00
    : sel_global ? img_global
    : sel_pie ? img_pie
    : sel_pir ? img_pir
    : sel_ctrl ? img_ctrl
    : 8'h00;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      global_irq_enable_ff <=
        lvd_ctrl_pkg::RST_INTERRUPT_GLOBAL_CONTROL[lvd_ctrl_pkg::BIT_GLOBAL_IRQ_ENABLE];
      peripheral_irq_enable_ff <=
        lvd_ctrl_pkg::RST_INTERRUPT_GLOBAL_CONTROL[lvd_ctrl_pkg::BIT_PERIPHERAL_IRQ_ENABLE];
      low_voltage_irq_enable_ff <= lvd_ctrl_pkg::RST_PERIPHERAL_INTERRUPT_ENABLE_ONE[
        lvd_ctrl_pkg::BIT_LOW_VOLTAGE_IRQ_ENABLE];
      low_voltage_event_flag_ff <= lvd_ctrl_pkg::RST_PERIPHERAL_INTERRUPT_FLAGS_ONE[
        lvd_ctrl_pkg::BIT_LOW_VOLTAGE_EVENT_FLAG];
      detector_enable_ff <=
        lvd_ctrl_pkg::RST_VOLTAGE_DETECT_CONTROL[lvd_ctrl_pkg::BIT_DETECTOR_ENABLE];
      trip_level_select_ff <= lvd_ctrl_pkg::TRIP_RESET;
    end else begin
      global_irq_enable_ff <= nxt_global_irq_enable;
      peripheral_irq_enable_ff <= nxt_peripheral_irq_enable;
      low_voltage_irq_enable_ff <= nxt_low_voltage_irq_enable;
      low_voltage_event_flag_ff <= nxt_low_voltage_event_flag;
      detector_enable_ff <= nxt_detector_enable;
      trip_level_select_ff <= nxt_trip_level_select;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      supply_prev_ff <= 1'b0;
      arm_cnt_ff <= 2'h0;
      rdata_ff <= 8'h00;
    end else begin
      supply_prev_ff <= nxt_supply_prev;
      arm_cnt_ff <= nxt_arm_cnt;
      rdata_ff <= nxt_rdata;
    end
  end

  // The trip code is passed straight to the analog ladder; the reserved code
  // is stored and returned as written, with no level implied.
  assign detector_enable = detector_enable_ff;
  assign trip_level_select = trip_level_select_ff;
  assign reg_rdata = rdata_ff;

  // Wake-up ignores the global enable so that the core resumes even with
  // interrupts masked; vectoring then depends on the global enable alone.
  assign wake_req = low_voltage_event_flag_ff && low_voltage_irq_enable_ff
    && peripheral_irq_enable_ff;
  assign irq_req = wake_req && global_irq_enable_ff;
  assign vector_after_wake = wake_req && global_irq_enable_ff;

  // Checks.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  sequence s_enabled_high;
    detector_enable_ff && armed && supply_above_sync;
  endsequence

  sequence s_falls;
    detector_enable_ff && !supply_above_sync;
  endsequence

  sequence s_sw_clear;
    reg_wr && sel_pir && !reg_wdata[lvd_ctrl_pkg::BIT_LOW_VOLTAGE_EVENT_FLAG];
  endsequence

  AST_EDGE_SETS_FLAG: assert property (s_enabled_high ##1 s_falls |=>
    low_voltage_event_flag_ff)
    else $error("Supply fall did not set the event flag.");

  AST_LEVEL_NO_SET: assert property (
    (!low_voltage_event_flag_ff && !supply_above_sync && !supply_prev_ff
     && !(reg_wr && sel_pir)) |=> !low_voltage_event_flag_ff)
    else $error("Flag set by a steady low level.");

  AST_FLAG_STICKY: assert property (
    (low_voltage_event_flag_ff && !(reg_wr && sel_pir)) |=> low_voltage_event_flag_ff)
    else $error("Event flag cleared without a software write.");

  AST_CLEAR_LOSES_TO_EDGE: assert property (
    (s_sw_clear and (supply_prev_ff && detector_enable_ff && !supply_above_sync))
    |=> low_voltage_event_flag_ff)
    else $error("Simultaneous event lost to a software clear.");

  AST_SW_SET: assert property (
    (reg_wr && sel_pir && reg_wdata[lvd_ctrl_pkg::BIT_LOW_VOLTAGE_EVENT_FLAG]
     && low_voltage_irq_enable_ff && peripheral_irq_enable_ff && global_irq_enable_ff
     && !(reg_wr && sel_global) && !(reg_wr && sel_pie)) |=> irq_req)
    else $error("Software-set flag did not raise the interrupt.");

  AST_IRQ_TERMS: assert property (
    irq_req == (low_voltage_event_flag_ff && low_voltage_irq_enable_ff
                && peripheral_irq_enable_ff && global_irq_enable_ff))
    else $error("Interrupt request not equal to the enable product.");

  AST_WAKE_NO_GLOBAL: assert property (
    (wake_req && !global_irq_enable_ff) |-> !vector_after_wake && !irq_req)
    else $error("Vectoring requested without global enable.");

  AST_DISABLED_QUIET: assert property (
    (!detector_enable_ff && !low_voltage_event_flag_ff && !(reg_wr && sel_pir))
    |=> !low_voltage_event_flag_ff)
    else $error("Flag set while detector disabled.");

  AST_CTRL_READBACK: assert property (
    (reg_rd && sel_ctrl) |=> (reg_rdata[7:6] == 2'h0) && !reg_rdata[3]
      && (reg_rdata[2:0] == $past(trip_level_select_ff))
      && (reg_rdata[4] == $past(detector_enable_ff)))
    else $error("Control read image wrong.");

  AST_STABLE_READ: assert property (
    (reg_rd && sel_ctrl) |=> reg_rdata[lvd_ctrl_pkg::BIT_REFERENCE_STABLE_STATUS]
      == $past(reference_stable_status))
    else $error("Stable status not returned on read.");

  AST_STABLE_RO: assert property (
    (reg_wr && sel_ctrl && reg_wdata[lvd_ctrl_pkg::BIT_REFERENCE_STABLE_STATUS]
     && !$past(reference_stable_raw)) |=> !reference_stable_status)
    else $error("Stable status disturbed by a write.");

  AST_TRIP_WRITE: assert property (
    (reg_wr && sel_ctrl) |=> trip_level_select == $past(reg_wdata[2:0])
      && detector_enable == $past(reg_wdata[4]))
    else $error("Control write not applied.");

  AST_RESET_LEVEL: assert property (
    $fell(srst) |-> trip_level_select == lvd_ctrl_pkg::TRIP_2V3 && !detector_enable)
    else $error("Trip level after reset is not 2.3V.");

  AST_SYNC_DELAY: assert property (
    $rose(supply_above_trip) ##1 supply_above_trip ##1 supply_above_trip
    |-> supply_above_sync)
    else $error("Synchroniser latency not two cycles.");

  AST_READ_ONE_CYCLE: assert property (
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("Read data held beyond its cycle.");

endmodule // lvd_ctrl

`default_nettype wire

// >>> test/lvd_analog_model.sv
/*
  Behavioural model of the analog supply comparator and reference ladder.
  Assumes the bench sets the supply in millivolts and that core_clk runs.
*/
`timescale 1ns/1ns
`default_nettype none

module lvd_analog_model #(
  parameter int STABLE_CYC = 16
) (
  input wire logic core_clk,
  input wire logic detector_enable,
  input wire logic [2:0] trip_level_select,
  input var int supply_mv,
  output logic supply_above_trip,
  output logic reference_stable_raw
);
  logic above_ff = 1'b1;
  int settle_ff = 0;

  function automatic int trip_mv(input logic [2:0] code);
    case (code)
      3'h7: return 4500;
      3'h6: return 4200;
      3'h5: return 4000;
      3'h4: return 2300;
      3'h3: return 2200;
      3'h2: return 2100;
      3'h1: return 2000;
      default: return 0;
    endcase
  endfunction

  // A powered-down comparator gives garbage, so the output toggles every cycle.
  always @(posedge core_clk) begin
    if (!detector_enable) begin
      settle_ff <= 0;
      above_ff <= ~above_ff;
    end else begin
      if (settle_ff < STABLE_CYC) settle_ff <= settle_ff + 1;
      above_ff <= supply_mv > trip_mv(trip_level_select);
    end
  end

  assign supply_above_trip = above_ff;
  assign reference_stable_raw = detector_enable && (settle_ff >= STABLE_CYC);
endmodule // lvd_analog_model

`default_nettype wire

// >>> test/lvd_ctrl_tb_top.sv
/*
  Self-checking bench for the voltage detector control block.
  Assumes the analog model stands in for the detector and reference.
*/
`timescale 1ns/1ns
`default_nettype none

module lvd_ctrl_tb_top;
  localparam int STABLE_CYC = 16;
  logic core_clk, srst, reg_wr, reg_rd, rd_seen;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic supply_above_trip, reference_stable_raw, detector_enable;
  logic [2:0] trip_level_select;
  logic irq_req, wake_req, vector_after_wake;
  int supply_mv, n_errors, n_checks;
  logic [7:0] exp_q[$];

  lvd_ctrl u_dut (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .supply_above_trip(supply_above_trip), .reference_stable_raw(reference_stable_raw),
    .detector_enable(detector_enable), .trip_level_select(trip_level_select),
    .irq_req(irq_req), .wake_req(wake_req), .vector_after_wake(vector_after_wake));

  lvd_analog_model #(.STABLE_CYC(STABLE_CYC)) u_analog (.core_clk(core_clk),
    .detector_enable(detector_enable), .trip_level_select(trip_level_select),
    .supply_mv(supply_mv), .supply_above_trip(supply_above_trip),
    .reference_stable_raw(reference_stable_raw));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic results;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic outs(input logic i, input logic w, input logic v);
    chk("irq_req", {7'h0, i}, {7'h0, irq_req});
    chk("wake_req", {7'h0, w}, {7'h0, wake_req});
    chk("vector_after_wake", {7'h0, v}, {7'h0, vector_after_wake});
  endtask

  task automatic wait_irq;
    for (int i = 0; i < 10 && irq_req !== 1'b1; i++) tick(1);
  endtask

  // Read data stand only in the cycle after the strobe, so compare exactly there.
  always @(posedge core_clk) begin
    if (rd_seen) begin
      if (exp_q.size() == 0) chk("read queue", 8'h01, 8'h00);
      else chk("reg_rdata", exp_q.pop_front(), reg_rdata);
    end
    rd_seen = reg_rd;
  end

  initial begin
    #(50 * 4000);
    n_errors++;
    results();
  end

  initial begin
    logic [7:0] rnd;
    srst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    rd_seen = 1'b0;
    supply_mv = 3000;
    n_errors = 0;
    n_checks = 0;
    void'($urandom(17));
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    tick(1);
    chk("trip_level_select", {5'h0, lvd_ctrl_pkg::TRIP_RESET}, {5'h0, trip_level_select});
    chk("detector_enable", 8'h00, {7'h0, detector_enable});
    outs(1'b0, 1'b0, 1'b0);
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h00);
    rd(4'h2, 8'h00);
    rd(4'h3, lvd_ctrl_pkg::RST_VOLTAGE_DETECT_CONTROL);
    wr(4'h0, 8'hff);
    rd(4'h0, 8'hc0);
    wr(4'h0, 8'h00);
    wr(4'h9, 8'hff);
    rd(4'h9, 8'h00);
    // Codes are swept with the detector off, so a toggling comparator must not set the flag.
    for (int c = 0; c < 8; c++) begin
      rnd = 8'($urandom()) & 8'hc8;
      wr(4'h3, rnd | 8'(c));
      tick(1);
      chk("trip_level_select", 8'(c), {5'h0, trip_level_select});
      rd(4'h3, 8'(c));
    end
    rd(4'h2, 8'h00);
    wr(4'h3, 8'h14);
    tick(1);
    chk("detector_enable", 8'h01, {7'h0, detector_enable});
    rd(4'h3, 8'h14);
    tick(STABLE_CYC + 4);
    rd(4'h3, 8'h34);
    wr(4'h2, 8'h00);
    wr(4'h0, 8'hc0);
    wr(4'h1, 8'h40);
    tick(1);
    outs(1'b0, 1'b0, 1'b0);
    supply_mv = 2000;
    wait_irq();
    outs(1'b1, 1'b1, 1'b1);
    rd(4'h2, 8'h40);
    supply_mv = 3000;
    tick(10);
    outs(1'b1, 1'b1, 1'b1);
    wr(4'h0, 8'h40);
    tick(1);
    outs(1'b0, 1'b1, 1'b0);
    wr(4'h1, 8'h00);
    tick(1);
    outs(1'b0, 1'b0, 1'b0);
    wr(4'h1, 8'h40);
    wr(4'h0, 8'hc0);
    wr(4'h2, 8'h00);
    tick(1);
    outs(1'b0, 1'b0, 1'b0);
    supply_mv = 2000;
    wait_irq();
    outs(1'b1, 1'b1, 1'b1);
    wr(4'h2, 8'h00);
    tick(10);
    outs(1'b0, 1'b0, 1'b0);
    supply_mv = 3000;
    tick(5);
    wr(4'h2, 8'h40);
    tick(1);
    outs(1'b1, 1'b1, 1'b1);
    wr(4'h2, 8'h00);
    wr(4'h3, 8'h04);
    tick(10);
    outs(1'b0, 1'b0, 1'b0);
    rd(4'h3, 8'h04);
    supply_mv = 2000;
    wr(4'h3, 8'h14);
    tick(10);
    outs(1'b0, 1'b0, 1'b0);
    tick(2);
    results();
  end
endmodule // lvd_ctrl_tb_top

`default_nettype wire
